/* sac_pkg.sv */
// shared constants for the conversion sequencer and its start controller
`default_nettype none
package sac_pkg;
    localparam int unsigned CLK_HZ          = 25000000;
    localparam int unsigned CONV_CLOCKS     = 40;
    localparam int unsigned GUARD_CLOCKS    = 4;
    localparam int unsigned RATE_DIVISOR    = 44;
    localparam int unsigned XFER_NS         = 200;
    // latch transfer time rounded down, at least one cycle
    localparam int unsigned XFER_CYC_RAW    = (XFER_NS * (CLK_HZ / 1000000)) / 1000;
    localparam int unsigned XFER_CYCLES     = (XFER_CYC_RAW < 1) ? 1 : XFER_CYC_RAW;
    localparam int unsigned DELAY_STAGES    = 4;
    localparam logic [3:0]  CNT_LOAD        = 4'hB;
    localparam logic [7:0]  RESULT_RESET    = 8'h00;
    localparam logic [7:0]  MIDPOINT        = 8'h80;
    localparam logic [5:0]  CONV_CNT_RESET  = 6'h00;
    localparam logic [5:0]  CONV_LAST       = 6'(CONV_CLOCKS - 1);
    localparam logic [5:0]  TRIAL_FIRST     = 6'(CONV_CLOCKS - 8);
    localparam logic [2:0]  GUARD_LAST      = 3'(GUARD_CLOCKS - 1);
    localparam logic [3:0]  XFER_LAST       = 4'(XFER_CYCLES - 1);
    typedef enum logic [1:0] {
        SAC_CTL_FREE  = 2'b00,
        SAC_CTL_DELAY = 2'b01,
        SAC_CTL_COUNT = 2'b10
    } sac_ctl_mode_e;
endpackage
`default_nettype wire

/* sac_link_if.sv */
// link between converter sequencer and host start controller
`default_nettype none
interface sac_link_if;
    import sac_pkg::*;
    logic       start;
    logic       done;
    logic [7:0] data_out;
    logic [7:0] data_oe_n;
    logic [7:0] data_bus;
    logic       read_en;
    // bus level worked out from the enables, pulled high when idle
    for (genvar b = 0; b < 8; b++) begin : g_bus
        assign data_bus[b] = data_oe_n[b] ? 1'b1 : data_out[b];
    end
    modport device (input start, input read_en, output done, output data_out, output data_oe_n);
    modport host   (output start, output read_en, input done, input data_bus);
endinterface
`default_nettype wire

/* sac_converter.sv */
// successive approximation sequencer with output latch
// ------------------------------------------------------------
// ------------------------------------------------------------
`default_nettype none
module sac_converter
    import sac_pkg::*;
(
    input  wire logic       i_mclk,
    input  wire logic       i_reset,
    input  wire logic       i_comp_high,
    sac_link_if.device      link,
    output logic            o_busy,
    output logic [7:0]      o_trial
);
    // ------------------------------------------------------------
    // sequencing
    // ------------------------------------------------------------
    logic [5:0] cnt_q;
    logic       busy_q;
    logic       start_q;
    logic [7:0] appr_q;
    logic [7:0] bit_q;
    logic [7:0] latch_q;
    logic       done_q;
    logic [3:0] xfer_q;
    logic       xfer_act_q;
    logic [2:0] guard_q;
    logic       guard_act_q;
    wire        start_rise = link.start & ~start_q;
    // guard interval ignores starts, as the host is warned
    wire        accept     = start_rise & ~guard_act_q;
    wire        trial_en   = busy_q & (cnt_q >= TRIAL_FIRST) & (bit_q != 8'h00);
    wire        finish     = busy_q & (cnt_q == CONV_LAST);
    // a restart on the last edge must not load a half-done word into the latch
    wire        complete   = finish & ~accept;
    wire [7:0]  kept       = i_comp_high ? appr_q : (appr_q & ~bit_q);
    wire [7:0]  next_bit   = bit_q >> 1;
    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            cnt_q   <= CONV_CNT_RESET;
            busy_q  <= 1'b0;
            start_q <= 1'b0;
            appr_q  <= RESULT_RESET;
            bit_q   <= 8'h00;
        end else begin
            start_q <= link.start;
            if (accept) begin
                cnt_q  <= CONV_CNT_RESET;
                busy_q <= 1'b1;
                appr_q <= MIDPOINT;
                bit_q  <= MIDPOINT;
            end else if (busy_q) begin
                cnt_q <= cnt_q + 6'h01;
                if (finish) begin
                    busy_q <= 1'b0;
                end
                // the last trial shares its edge with finish, so the lsb is decided too
                if (trial_en) begin
                    appr_q <= kept | next_bit;
                    bit_q  <= next_bit;
                end
            end
        end
    end
    // ------------------------------------------------------------
    // output latch and completion flag
    // ------------------------------------------------------------
    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            latch_q     <= ~RESULT_RESET;
            done_q      <= 1'b1;
            xfer_q      <= 4'h0;
            xfer_act_q  <= 1'b0;
            guard_q     <= 3'h0;
            guard_act_q <= 1'b0;
        end else begin
            if (accept) begin
                done_q <= 1'b0;
            end else if (finish) begin
                done_q <= 1'b1;
            end
            // transfer begins with done rising and lasts the latch time
            if (complete) begin
                xfer_act_q <= 1'b1;
                xfer_q     <= 4'h0;
            end else if (xfer_act_q) begin
                if (xfer_q == XFER_LAST) begin
                    xfer_act_q <= 1'b0;
                    latch_q    <= ~appr_q;
                end else begin
                    xfer_q <= xfer_q + 4'h1;
                end
            end
            if (complete) begin
                guard_act_q <= 1'b1;
                guard_q     <= 3'h0;
            end else if (guard_act_q) begin
                if (guard_q == GUARD_LAST) begin
                    guard_act_q <= 1'b0;
                end else begin
                    guard_q <= guard_q + 3'h1;
                end
            end
        end
    end
    // approximation register is not disturbed by a late comparator edge
    assign link.done      = done_q;
    assign link.data_out  = latch_q;
    assign link.data_oe_n = {8{~link.read_en}};
    assign o_busy         = busy_q;
    assign o_trial        = appr_q;
endmodule
`default_nettype wire

/* sac_start_ctl.sv */
// host-side start controller: free run, delayed start and counter modes
`default_nettype none
module sac_start_ctl
    import sac_pkg::*;
(
    input  wire logic          i_mclk,
    input  wire logic          i_reset,
    input  wire sac_ctl_mode_e i_mode,
    input  wire logic          i_request,
    input  wire logic          i_run_n,
    input  wire logic          i_read,
    sac_link_if.host           link,
    output logic [7:0]         o_data,
    output logic               o_carry
);
    // ------------------------------------------------------------
    // request capture and delay
    // ------------------------------------------------------------
    logic       req_q;
    logic [3:0] shift_q;
    logic       ff_q;
    logic       done_q;
    logic [3:0] cnt_q;
    logic       cnt_en_q;
    logic       carry_q;
    logic       pulse_q;
    logic [7:0] data_q;
    wire        done_fall = ~link.done & done_q;
    wire        mode_dly  = (i_mode == SAC_CTL_DELAY);
    wire        mode_cnt  = (i_mode == SAC_CTL_COUNT);
    // one-clock pulse as the request reaches the third stage, one before the last
    wire        dly_pulse = shift_q[2] & ~shift_q[3];
    // the carry gates the next pulse, so starts stay clear of the guard
    wire        cnt_pulse = req_q & ~pulse_q & ~cnt_en_q & link.done & ~carry_q;
    // outside delayed mode the shift register keeps the done history
    wire        shift_in  = mode_dly ? req_q : link.done;
    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            req_q       <= 1'b0;
            shift_q     <= 4'h0;
            ff_q        <= 1'b0;
            done_q      <= 1'b1;
            cnt_q       <= 4'h0;
            cnt_en_q    <= 1'b0;
            carry_q     <= 1'b0;
            pulse_q     <= 1'b0;
            data_q      <= 8'h00;
        end else begin
            done_q      <= link.done;
            // clear input stops free running; done must stand past the guard first
            ff_q <= i_run_n ? 1'b0 : ((link.done & shift_q[3]) | i_request);
            shift_q <= {shift_q[2:0], shift_in};
            if (i_request) begin
                req_q <= 1'b1;
            end else if ((mode_dly & done_fall) | (mode_cnt & carry_q)) begin
                req_q <= 1'b0;
            end
            pulse_q <= mode_cnt & cnt_pulse;
            carry_q <= 1'b0;
            if (pulse_q) begin
                cnt_q    <= CNT_LOAD;
                cnt_en_q <= 1'b1;
            end else if (cnt_en_q & (link.done | cnt_q != CNT_LOAD)) begin
                cnt_q <= cnt_q + 4'h1;
                if (cnt_q == 4'hE) begin
                    carry_q  <= 1'b1;
                    cnt_en_q <= 1'b0;
                end
            end
            if (i_read) begin
                data_q <= link.data_bus;
            end
        end
    end
    assign link.start   = mode_dly ? dly_pulse : (mode_cnt ? pulse_q : ff_q);
    assign link.read_en = i_read;
    assign o_data       = data_q;
    assign o_carry      = carry_q;
endmodule
`default_nettype wire

/* sac_link_props.sv */
// link assertions for the converter and its start controller
`default_nettype none
module sac_link_props (
    input wire logic       i_mclk,
    input wire logic       i_reset,
    input wire logic       start,
    input wire logic       done,
    input wire logic [7:0] data_out,
    input wire logic [7:0] data_oe_n,
    input wire logic       read_en
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       start_q, done_q;
    logic [2:0] rise_q;
    logic [5:0] conv_q;
    // starts in the last three cycles of the guard window are left out, the device may drop them
    wire       acc    = start && !start_q && (!done || rise_q >= 3'h4);
    wire [2:0] rise_d = (done && !done_q) ? 3'h1 : rise_q + 3'(rise_q != 3'h7);
    wire [5:0] conv_d = acc ? 6'h01 : conv_q + 6'(conv_q != 6'h3F);
    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            {start_q, done_q, rise_q, conv_q} <= {2'h1, 3'h7, 6'h3F};
        end else begin
            {start_q, done_q, rise_q, conv_q} <= {start, done, rise_d, conv_d};
        end
    end
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_reset);
    sequence s_busy_start;
        !done && $rose(start);
    endsequence
    a_done_falls: assert property (acc |=> !done) else $error("done stayed high");
    a_busy_span: assert property (conv_q inside {[6'h01:6'h28]} |-> !done)
        else $error("done rose early");
    a_conv_end: assert property (conv_q == 6'h29 |-> done) else $error("done late");
    a_done_holds: assert property (done && !start |=> done) else $error("done fell");
    a_restart_busy: assert property (s_busy_start |=> (!done) [*8])
        else $error("restart ended early");
    a_latch_quiet: assert property (!done |=> $stable(data_out))
        else $error("latch moved while busy");
    a_latch_time: assert property ($changed(data_out) |-> $past(done) && rise_q == 3'h5)
        else $error("latch moved at wrong time");
    a_bus_drive: assert property (data_oe_n == {8{!read_en}})
        else $error("bus enable wrong");
endmodule
`default_nettype wire

/* tb_top.sv */
// bench: converter and start controller joined by their link
`default_nettype none
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin n_errors++; \
    $display("mismatch %s expected %h seen %h", n, e, g); end end
module tb_top
    import sac_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic          i_mclk = 1'h0, i_reset = 1'h1, request = 1'h0, run_n = 1'h1, read = 1'h0;
    logic          busy, carry, done_p;
    logic [7:0]    target = 8'h00, trial, data;
    sac_ctl_mode_e mode = SAC_CTL_COUNT;
    int            n_errors = 0, checks_done = 0, n_carry = 0, n_rise = 0, cyc = 0;
    logic [7:0]    vals [5] = '{8'h00, 8'hFF, 8'h80, 8'h7F, 8'h5A};
    // input sits half a step above target, so the exact code is target
    wire           comp_high = (target >= trial);
    sac_link_if sac_link_if_i ();
    always #20 i_mclk = ~i_mclk;
    always @(posedge i_mclk) begin
        cyc <= cyc + 1;
        done_p <= sac_link_if_i.done;
        n_carry <= n_carry + int'(carry === 1'h1);
        n_rise <= n_rise + int'(sac_link_if_i.done === 1'h1 && done_p === 1'h0);
    end
    sac_converter sac_converter_i (.i_mclk(i_mclk), .i_reset(i_reset), .i_comp_high(comp_high),
        .link(sac_link_if_i), .o_busy(busy), .o_trial(trial));
    sac_start_ctl sac_start_ctl_i (.i_mclk(i_mclk), .i_reset(i_reset), .i_mode(mode),
        .i_request(request), .i_run_n(run_n), .i_read(read), .link(sac_link_if_i),
        .o_data(data), .o_carry(carry));
    sac_link_props sac_link_props_i (.i_mclk(i_mclk), .i_reset(i_reset),
        .start(sac_link_if_i.start), .done(sac_link_if_i.done),
        .data_out(sac_link_if_i.data_out), .data_oe_n(sac_link_if_i.data_oe_n),
        .read_en(sac_link_if_i.read_en));
    task automatic test_done;
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic wait_done(input logic lvl);
        int k = 0;
        while (sac_link_if_i.done !== lvl && k < 300) begin
            @(posedge i_mclk);
            k++;
        end
        if (sac_link_if_i.done !== lvl) begin
            `CHK("done_wait", lvl, sac_link_if_i.done)
            test_done();
        end
    endtask
    task automatic pulse;
        request <= 1'h1;
        repeat (2) @(posedge i_mclk);
        request <= 1'h0;
    endtask
    task automatic read_data(input string n, input logic [7:0] t);
        repeat (8) @(posedge i_mclk);
        read <= 1'h1;
        repeat (3) @(posedge i_mclk);
        `CHK(n, ~t, data)
        read <= 1'h0;
        $display("test %s finished", n);
    endtask
    task automatic convert(input logic [7:0] t, input sac_ctl_mode_e m, input string n,
        input logic re);
        int c0 = n_carry;
        int c1 = 0;
        target <= t;
        mode <= m;
        pulse();
        wait_done(1'h0);
        c1 = cyc;
        `CHK("busy_high", 1'h1, busy)
        `CHK("first_trial", MIDPOINT, trial)
        // a second request while busy must restart with the new input
        if (re) begin
            repeat (10) @(posedge i_mclk);
            target <= ~t;
            pulse();
        end
        wait_done(1'h1);
        `CHK("conv_len", 1'h1, re ? (cyc - c1 > 45) : (cyc - c1 == 40))
        `CHK("busy_low", 1'h0, busy)
        read_data(n, re ? ~t : t);
        if (m == SAC_CTL_COUNT) `CHK("carry_count", c0 + 1, n_carry)
    endtask
    task automatic burst(input sac_ctl_mode_e m, input string n);
        int r0 = n_rise;
        mode <= m;
        run_n <= (m != SAC_CTL_FREE);
        request <= (m == SAC_CTL_COUNT);
        repeat (150) @(posedge i_mclk);
        run_n <= 1'h1;
        request <= 1'h0;
        wait_done(1'h1);
        `CHK("runs_seen", 1'h1, (n_rise - r0 >= 2))
        read_data(n, target);
    endtask
    initial begin
        repeat (12) @(posedge i_mclk);
        i_reset <= 1'h0;
        @(posedge i_mclk);
        foreach (vals[j]) convert(vals[j], SAC_CTL_COUNT, "count_conv", 1'h0);
        convert(8'h3C, SAC_CTL_DELAY, "delay_conv", 1'h0);
        convert(8'h96, SAC_CTL_DELAY, "restart_conv", 1'h1);
        burst(SAC_CTL_FREE, "free_run");
        burst(SAC_CTL_COUNT, "held_request");
        test_done();
    end
endmodule
`default_nettype wire
